//--- src/uart_aux_pkg.sv
// Constants and types for the UART auxiliary control and status block
package uart_aux_pkg;

   // ==========================================================
   // Bus geometry
   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;
   localparam int REG_W = 16;
   localparam int CHAR_W = 8;
   localparam int FIFO_DEPTH_DEF = 16;

   // ==========================================================
   // Register byte addresses
   localparam logic [ADDR_W-1:0] ADDR_TX_FILL = 32'h5000_1180;
   localparam logic [ADDR_W-1:0] ADDR_RX_FILL = 32'h5000_1184;
   localparam logic [ADDR_W-1:0] ADDR_SOFT_RESET = 32'h5000_1188;
   localparam logic [ADDR_W-1:0] ADDR_FLOW_SHADOW = 32'h5000_118c;
   localparam logic [ADDR_W-1:0] ADDR_BREAK_SHADOW = 32'h5000_1190;
   localparam logic [ADDR_W-1:0] ADDR_MODEM_CTRL = 32'h5000_1200;
   localparam logic [ADDR_W-1:0] ADDR_LINE_CTRL = 32'h5000_1204;
   localparam logic [ADDR_W-1:0] ADDR_FIFO_CTRL = 32'h5000_1208;

   // ==========================================================
   // Field positions
   localparam int BIT_SOFT_RESET = 0;
   localparam int BIT_RX_FLUSH = 1;
   localparam int BIT_TX_FLUSH = 2;
   localparam int BIT_MIRROR = 0;
   localparam int BIT_MCR_RTS = 1;
   localparam int BIT_MCR_LOOP = 4;
   localparam int BIT_MCR_AUTO_FLOW = 5;
   localparam int BIT_MCR_INFRARED = 6;
   localparam int BIT_LCR_BREAK = 6;
   localparam int BIT_FCR_ENABLE = 0;
   localparam int BIT_FCR_TRIG_LO = 6;
   localparam int BIT_FCR_TRIG_HI = 7;

   // ==========================================================
   // Reset values and codes
   localparam logic [REG_W-1:0] REG_RESET = 16'h0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] TRIG_ONE = 2'h0;
   localparam logic [1:0] TRIG_QUARTER = 2'h1;
   localparam logic [1:0] TRIG_HALF = 2'h2;
   localparam int TRIG_GAP_FROM_FULL = 2;

   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 4;
   localparam int IR_PULSE_PERIOD_NS = 1600;
   localparam int IR_PULSE_CYCLES = IR_PULSE_PERIOD_NS / CLK_PERIOD_NS;

   typedef enum logic [3:0] {
      SEL_TX_FILL, SEL_RX_FILL, SEL_SOFT_RESET, SEL_FLOW_SHADOW, SEL_BREAK_SHADOW,
      SEL_MODEM_CTRL, SEL_LINE_CTRL, SEL_FIFO_CTRL, SEL_NONE
   } reg_sel_t;

endpackage

//--- src/uart_shadow_control_regs.sv
// UART auxiliary control: FIFO fill counts, flushes, soft reset, shadow bits
// Functional notes
// - Transmit FIFO entry count readable, 16 bits
// - Receive FIFO entry count readable, 16 bits
// - Transmit flush bit empties transmit FIFO
// - Receive flush bit empties receive FIFO
// - Flush bits clear themselves after acting
// - Soft reset asserts asynchronously, releases synchronously
// - Soft reset covers every clock domain
// - Request shadow shares modem control request bit
// - Request output low when bit set
// - Auto flow with FIFO enabled forces request high above trigger
// - Loopback holds request output high
// - Loopback feeds request bit to modem input
// - Break shadow shares line control break bit
// - Break without loopback holds serial output low
// - Break in infrared mode pulses infrared output
// - Break in loopback reaches own receiver
`timescale 1ns/1ps
`default_nettype none

module uart_shadow_control_regs #(
   parameter int FIFO_DEPTH = uart_aux_pkg::FIFO_DEPTH_DEF
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_srst,
   // AXI4-Lite write address and data
   input wire logic [uart_aux_pkg::ADDR_W-1:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [uart_aux_pkg::DATA_W-1:0] i_wdata,
   input wire logic [uart_aux_pkg::DATA_W/8-1:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   // AXI4-Lite read
   input wire logic [uart_aux_pkg::ADDR_W-1:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [uart_aux_pkg::DATA_W-1:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   // Transmit FIFO fill side and drain side
   input wire logic i_tx_valid,
   input wire logic [uart_aux_pkg::CHAR_W-1:0] i_tx_data,
   output logic o_tx_ready,
   output logic o_txq_valid,
   output logic [uart_aux_pkg::CHAR_W-1:0] o_txq_data,
   input wire logic i_txq_ready,
   // Receive FIFO fill side and drain side
   input wire logic i_rx_valid,
   input wire logic [uart_aux_pkg::CHAR_W-1:0] i_rx_data,
   output logic o_rx_ready,
   output logic o_rxq_valid,
   output logic [uart_aux_pkg::CHAR_W-1:0] o_rxq_data,
   input wire logic i_rxq_ready,
   // Serial datapath in, line outputs
   input wire logic i_ser_out,
   input wire logic i_sir_out_n,
   output logic o_sout,
   output logic o_sir_out_n,
   output logic o_rts_n,
   // Loopback paths and controller state
   output logic o_loop_cts,
   output logic o_loop_rxd,
   output logic o_loopback,
   output logic o_fifo_enable,
   output logic o_core_rst
);
   import uart_aux_pkg::*;
   localparam int PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
   localparam int CNT_W = $clog2(FIFO_DEPTH + 1);
   localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(FIFO_DEPTH);
   localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(FIFO_DEPTH - 1);
   localparam logic [15:0] IR_LAST = 16'(IR_PULSE_CYCLES - 1);
   function automatic reg_sel_t decode(input logic [ADDR_W-1:0] addr);
      if (addr == ADDR_TX_FILL) return SEL_TX_FILL;
      else if (addr == ADDR_RX_FILL) return SEL_RX_FILL;
      else if (addr == ADDR_SOFT_RESET) return SEL_SOFT_RESET;
      else if (addr == ADDR_FLOW_SHADOW) return SEL_FLOW_SHADOW;
      else if (addr == ADDR_BREAK_SHADOW) return SEL_BREAK_SHADOW;
      else if (addr == ADDR_MODEM_CTRL) return SEL_MODEM_CTRL;
      else if (addr == ADDR_LINE_CTRL) return SEL_LINE_CTRL;
      else if (addr == ADDR_FIFO_CTRL) return SEL_FIFO_CTRL;
      else return SEL_NONE;
   endfunction
   function automatic logic [PTR_W-1:0] next_ptr(input logic [PTR_W-1:0] p);
      return (p == PTR_LAST) ? '0 : PTR_W'(p + 1'b1);
   endfunction
   // ==========================================================
   // Bus write channel
   logic aw_have;
   logic w_have;
   logic [ADDR_W-1:0] wr_addr;
   logic [DATA_W-1:0] wr_data;
   logic wr_lane0;
   wire aw_take = i_awvalid && o_awready;
   wire w_take = i_wvalid && o_wready;
   wire wr_fire = aw_have && w_have && !o_bvalid;
   wire b_done = o_bvalid && i_bready;
   wire next_aw_have = wr_fire ? 1'b0 : (aw_have || aw_take);
   wire next_w_have = wr_fire ? 1'b0 : (w_have || w_take);
   reg_sel_t wr_sel;
   assign wr_sel = decode(wr_addr);
   wire wr_ok = wr_fire && wr_lane0;
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         aw_have <= 1'b0;
         w_have <= 1'b0;
         wr_addr <= '0;
         wr_data <= '0;
         wr_lane0 <= 1'b0;
         o_awready <= 1'b0;
         o_wready <= 1'b0;
         o_bvalid <= 1'b0;
         o_bresp <= RESP_OKAY;
      end else begin
         aw_have <= next_aw_have;
         w_have <= next_w_have;
         o_awready <= !next_aw_have && !(o_bvalid && !b_done);
         o_wready <= !next_w_have && !(o_bvalid && !b_done);
         if (aw_take) begin
            wr_addr <= i_awaddr;
         end
         if (w_take) begin
            wr_data <= i_wdata;
            wr_lane0 <= i_wstrb[0];
         end
         if (wr_fire) begin
            o_bvalid <= 1'b1;
            o_bresp <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
         end else if (b_done) begin
            o_bvalid <= 1'b0;
         end
      end
   end
   // Decoded write strobes; flushes exist for this one cycle only
   wire wr_flow_shadow = wr_ok && (wr_sel == SEL_FLOW_SHADOW);
   wire wr_break_shadow = wr_ok && (wr_sel == SEL_BREAK_SHADOW);
   wire wr_modem = wr_ok && (wr_sel == SEL_MODEM_CTRL);
   wire wr_line = wr_ok && (wr_sel == SEL_LINE_CTRL);
   wire wr_fifo = wr_ok && (wr_sel == SEL_FIFO_CTRL);
   wire wr_soft = wr_ok && (wr_sel == SEL_SOFT_RESET);
   wire flush_tx = (wr_soft || wr_fifo) && wr_data[BIT_TX_FLUSH];
   wire flush_rx = (wr_soft || wr_fifo) && wr_data[BIT_RX_FLUSH];
   wire soft_hit = wr_soft && wr_data[BIT_SOFT_RESET];
   // ==========================================================
   // Soft reset: set at once, released through two clocked stages
   logic soft_req;
   logic [1:0] rst_sync;
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         soft_req <= 1'b0;
      end else begin
         soft_req <= soft_hit;
      end
   end
   always_ff @(posedge i_clk_sys or posedge soft_req) begin
      if (soft_req) begin
         rst_sync <= 2'h3;
      end else if (i_srst) begin
         rst_sync <= 2'h3;
      end else begin
         rst_sync <= {rst_sync[0], 1'b0};
      end
   end
   // i_srst sets the stages too, so core flops need no sync reset path
   wire core_rst = rst_sync[1];
   assign o_core_rst = rst_sync[1];
   // ==========================================================
   // Shared control bits; main and shadow registers write the same flop
   logic rts_bit;
   logic break_bit;
   logic loop_bit;
   logic auto_flow;
   logic infrared;
   logic fifo_en;
   logic [1:0] rx_trig;
   always_ff @(posedge i_clk_sys or posedge core_rst) begin
      if (core_rst) begin
         rts_bit <= 1'b0;
         break_bit <= 1'b0;
         loop_bit <= 1'b0;
         auto_flow <= 1'b0;
         infrared <= 1'b0;
         fifo_en <= 1'b0;
         rx_trig <= TRIG_ONE;
      end else begin
         if (wr_flow_shadow) begin
            rts_bit <= wr_data[BIT_MIRROR];
         end else if (wr_modem) begin
            rts_bit <= wr_data[BIT_MCR_RTS];
         end
         if (wr_modem) begin
            loop_bit <= wr_data[BIT_MCR_LOOP];
            auto_flow <= wr_data[BIT_MCR_AUTO_FLOW];
            infrared <= wr_data[BIT_MCR_INFRARED];
         end
         if (wr_break_shadow) begin
            break_bit <= wr_data[BIT_MIRROR];
         end else if (wr_line) begin
            break_bit <= wr_data[BIT_LCR_BREAK];
         end
         if (wr_fifo) begin
            fifo_en <= wr_data[BIT_FCR_ENABLE];
            rx_trig <= wr_data[BIT_FCR_TRIG_HI:BIT_FCR_TRIG_LO];
         end
      end
   end
   // ==========================================================
   // FIFOs with a two-entry output buffer; channel 0 transmit, 1 receive
   logic ch_in_ready [2];
   logic ch_out_valid [2];
   logic [CHAR_W-1:0] ch_out_data [2];
   logic [REG_W-1:0] ch_level [2];
   for (genvar g = 0; g < 2; g++) begin : g_chan
      logic [CHAR_W-1:0] mem [FIFO_DEPTH];
      logic [PTR_W-1:0] wptr;
      logic [PTR_W-1:0] rptr;
      logic [CNT_W-1:0] cnt;
      logic [1:0] held;
      logic [CHAR_W-1:0] slot1;
      wire in_valid = (g == 0) ? i_tx_valid : i_rx_valid;
      wire [CHAR_W-1:0] in_data = (g == 0) ? i_tx_data : i_rx_data;
      wire out_ready = (g == 0) ? i_txq_ready : i_rxq_ready;
      wire flush = (g == 0) ? flush_tx : flush_rx;
      wire push = in_valid && ch_in_ready[g];
      wire pop = ch_out_valid[g] && out_ready;
      wire [1:0] held_left = held - {1'b0, pop};
      wire move = (cnt != '0) && (held_left != 2'h2);
      wire [CNT_W-1:0] next_cnt = cnt + CNT_W'(push) - CNT_W'(move);
      wire [1:0] next_held = held_left + {1'b0, move};
      wire [CHAR_W-1:0] shifted0 = pop ? slot1 : ch_out_data[g];
      wire [CHAR_W-1:0] next_slot0 = (move && held_left == 2'h0) ? mem[rptr] : shifted0;
      wire [CHAR_W-1:0] next_slot1 = (move && held_left == 2'h1) ? mem[rptr] : slot1;
      // Storage carries no reset so it maps onto plain RAM
      always_ff @(posedge i_clk_sys) begin
         if (push) begin
            mem[wptr] <= in_data;
         end
      end
      always_ff @(posedge i_clk_sys or posedge core_rst) begin
         if (core_rst) begin
            wptr <= '0;
            rptr <= '0;
            cnt <= '0;
            held <= 2'h0;
            slot1 <= '0;
            ch_out_data[g] <= '0;
            ch_out_valid[g] <= 1'b0;
            ch_in_ready[g] <= 1'b0;
            ch_level[g] <= REG_RESET;
         end else if (flush) begin
            wptr <= '0;
            rptr <= '0;
            cnt <= '0;
            held <= 2'h0;
            ch_out_valid[g] <= 1'b0;
            ch_in_ready[g] <= 1'b1;
            ch_level[g] <= REG_RESET;
         end else begin
            if (push) begin
               wptr <= next_ptr(wptr);
            end
            if (move) begin
               rptr <= next_ptr(rptr);
            end
            cnt <= next_cnt;
            held <= next_held;
            slot1 <= next_slot1;
            ch_out_data[g] <= next_slot0;
            ch_out_valid[g] <= (next_held != 2'h0);
            ch_in_ready[g] <= (next_cnt < DEPTH_C);
            ch_level[g] <= REG_W'(next_cnt) + REG_W'(next_held);
         end
      end
   end
   assign o_tx_ready = ch_in_ready[0];
   assign o_txq_valid = ch_out_valid[0];
   assign o_txq_data = ch_out_data[0];
   assign o_rx_ready = ch_in_ready[1];
   assign o_rxq_valid = ch_out_valid[1];
   assign o_rxq_data = ch_out_data[1];
   // ==========================================================
   // Line outputs
   wire [REG_W-1:0] trig_level =
      (rx_trig == TRIG_ONE) ? REG_W'(1) :
      (rx_trig == TRIG_QUARTER) ? REG_W'(FIFO_DEPTH / 4) :
      (rx_trig == TRIG_HALF) ? REG_W'(FIFO_DEPTH / 2) :
      REG_W'(FIFO_DEPTH - TRIG_GAP_FROM_FULL);
   wire rx_above = ch_level[1] > trig_level;
   wire flow_hold = auto_flow && fifo_en && rx_above;
   wire next_rts_n = loop_bit ? 1'b1 : (!rts_bit || flow_hold);
   wire next_sout = loop_bit ? 1'b1 : (break_bit ? 1'b0 : i_ser_out);
   // The break pulse train is a fixed rate, independent of the baud divisor
   logic [15:0] ir_count;
   wire ir_tick = (ir_count == IR_LAST);
   wire next_sir_n = (break_bit && infrared) ? !ir_tick : i_sir_out_n;
   always_ff @(posedge i_clk_sys or posedge core_rst) begin
      if (core_rst) begin
         ir_count <= '0;
         o_rts_n <= 1'b1;
         o_sout <= 1'b1;
         o_sir_out_n <= 1'b1;
         o_loop_cts <= 1'b0;
         o_loop_rxd <= 1'b1;
         o_loopback <= 1'b0;
         o_fifo_enable <= 1'b0;
      end else begin
         ir_count <= ir_tick ? '0 : 16'(ir_count + 1'b1);
         o_rts_n <= next_rts_n;
         o_sout <= next_sout;
         o_sir_out_n <= next_sir_n;
         o_loop_cts <= loop_bit && rts_bit;
         o_loop_rxd <= break_bit ? 1'b0 : i_ser_out;
         o_loopback <= loop_bit;
         o_fifo_enable <= fifo_en;
      end
   end
   // ==========================================================
   // Bus read channel
   reg_sel_t rd_sel;
   logic [REG_W-1:0] rd_value;
   assign rd_sel = decode(i_araddr);
   wire ar_take = i_arvalid && o_arready;
   wire next_rvalid = ar_take ? 1'b1 : (o_rvalid && !i_rready);
   always_comb begin
      rd_value = REG_RESET;
      if (rd_sel == SEL_TX_FILL) begin
         rd_value = ch_level[0];
      end else if (rd_sel == SEL_RX_FILL) begin
         rd_value = ch_level[1];
      end else if (rd_sel == SEL_FLOW_SHADOW) begin
         rd_value[BIT_MIRROR] = rts_bit;
      end else if (rd_sel == SEL_BREAK_SHADOW) begin
         rd_value[BIT_MIRROR] = break_bit;
      end else if (rd_sel == SEL_MODEM_CTRL) begin
         rd_value[BIT_MCR_RTS] = rts_bit;
         rd_value[BIT_MCR_LOOP] = loop_bit;
         rd_value[BIT_MCR_AUTO_FLOW] = auto_flow;
         rd_value[BIT_MCR_INFRARED] = infrared;
      end else if (rd_sel == SEL_LINE_CTRL) begin
         rd_value[BIT_LCR_BREAK] = break_bit;
      end else if (rd_sel == SEL_FIFO_CTRL) begin
         rd_value[BIT_FCR_ENABLE] = fifo_en;
         rd_value[BIT_FCR_TRIG_HI:BIT_FCR_TRIG_LO] = rx_trig;
      end
   end
   always_ff @(posedge i_clk_sys) begin
      if (i_srst) begin
         o_arready <= 1'b0;
         o_rvalid <= 1'b0;
         o_rdata <= '0;
         o_rresp <= RESP_OKAY;
      end else begin
         o_arready <= !next_rvalid;
         o_rvalid <= next_rvalid;
         if (ar_take) begin
            o_rdata <= DATA_W'(rd_value);
            o_rresp <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
         end
      end
   end

endmodule // uart_shadow_control_regs

`default_nettype wire

//--- dv/uart_shadow_control_regs_asserts.sv
// Port-level checker for the UART auxiliary control block
`timescale 1ns/1ps
`default_nettype none
module uart_aux_chk (
   // Clock, reset and bus
   input wire logic i_clk_sys,
   input wire logic i_srst,
   input wire logic [uart_aux_pkg::ADDR_W-1:0] i_awaddr,
   input wire logic i_awvalid,
   input wire logic o_awready,
   input wire logic [uart_aux_pkg::DATA_W-1:0] i_wdata,
   input wire logic [uart_aux_pkg::DATA_W/8-1:0] i_wstrb,
   input wire logic i_wvalid,
   input wire logic o_wready,
   input wire logic [1:0] o_bresp,
   input wire logic o_bvalid,
   input wire logic i_bready,
   input wire logic [uart_aux_pkg::DATA_W-1:0] o_rdata,
   input wire logic o_rvalid,
   input wire logic i_rready,
   // Streams and line
   input wire logic o_txq_valid,
   input wire logic o_rxq_valid,
   input wire logic i_ser_out,
   input wire logic o_sout,
   input wire logic o_rts_n,
   input wire logic o_loopback,
   input wire logic o_core_rst
);
   import uart_aux_pkg::*;
   // =========================================
   // Captured write, so the effect can be tied to its cause
   logic [31:0] wa;
   logic [31:0] wd;
   logic ws;
   always_ff @(posedge i_clk_sys) begin
      if (i_awvalid && o_awready) wa <= i_awaddr;
      if (i_wvalid && o_wready) wd <= i_wdata;
      if (i_wvalid && o_wready) ws <= i_wstrb[0];
   end
   wire sr_ok = wa == ADDR_SOFT_RESET && ws && o_bresp == RESP_OKAY;
   // =========================================
   // Assertions
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_srst);
   a_loop_rts_idle: assert property (o_loopback |-> o_rts_n)
      else $error("request active in loopback");
   a_loop_sout_idle: assert property (o_loopback |-> o_sout)
      else $error("serial output low in loopback");
   a_sout_path: assert property (!o_loopback && o_sout && !o_core_rst && !$past(o_core_rst)
      |-> $past(i_ser_out)) else $error("serial output without source");
   a_tx_flush_empty: assert property ($rose(o_bvalid) && sr_ok && wd[BIT_TX_FLUSH]
      |-> ##[0:1] !o_txq_valid) else $error("transmit flush left data");
   a_rx_flush_empty: assert property ($rose(o_bvalid) && sr_ok && wd[BIT_RX_FLUSH]
      |-> ##[0:1] !o_rxq_valid) else $error("receive flush left data");
   a_soft_rst_go: assert property ($rose(o_bvalid) && sr_ok && wd[BIT_SOFT_RESET]
      |-> ##[0:3] o_core_rst) else $error("soft reset not raised");
   a_core_rst_quiet: assert property (o_core_rst && $past(o_core_rst) && !$past(i_srst)
      && !$past(i_srst, 2) |-> o_rts_n && o_sout && !o_txq_valid && !o_rxq_valid)
      else $error("controller active in soft reset");
   a_rd_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
      else $error("read answer dropped");
   a_wr_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
      else $error("write answer dropped");
   a_rd_width: assert property (o_rvalid |-> o_rdata[31:16] == 16'h0000)
      else $error("read data above field width");
endmodule // uart_aux_chk
bind uart_shadow_control_regs uart_aux_chk i_uart_aux_chk (.i_clk_sys, .i_srst, .i_awaddr,
   .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid,
   .i_bready, .o_rdata, .o_rvalid, .i_rready, .o_txq_valid, .o_rxq_valid, .i_ser_out,
   .o_sout, .o_rts_n, .o_loopback, .o_core_rst);
`default_nettype wire

//--- dv/modem_partner.sv
// Modem model: sends characters while request is active, drains transmit data
`timescale 1ns/1ps
`default_nettype none
module modem_partner (
   // Clock and control
   input wire logic i_clk_sys,
   input wire logic i_rts_n,
   input wire logic i_stall,
   // Characters into the UART
   output logic o_rx_valid,
   output logic [uart_aux_pkg::CHAR_W-1:0] o_rx_data,
   input wire logic i_rx_ready,
   // Characters out of the UART
   input wire logic i_txq_valid,
   input wire logic [uart_aux_pkg::CHAR_W-1:0] i_txq_data,
   output logic o_txq_ready
);
   import uart_aux_pkg::*;
   logic [CHAR_W-1:0] to_send[$];
   initial begin
      o_rx_valid = 1'b0;
      o_rx_data = 8'h5a;
      o_txq_ready = 1'b0;
   end
   // Idle data toggles so a stale character is never mistaken for a new one
   always @(posedge i_clk_sys) begin
      o_txq_ready <= !i_stall;
      if (o_rx_valid && i_rx_ready) begin
         o_rx_valid <= 1'b0;
         o_rx_data <= ~o_rx_data;
      end else if (!o_rx_valid && to_send.size() > 0 && !i_rts_n) begin
         o_rx_valid <= 1'b1;
         o_rx_data <= to_send.pop_front();
      end else if (!o_rx_valid) begin
         o_rx_data <= ~o_rx_data;
      end
   end
endmodule // modem_partner
`default_nettype wire

//--- dv/test_uart_shadow_control_regs.sv
// Self-checking bench for the UART auxiliary control block
`timescale 1ns/1ps
`default_nettype none
module test_uart_shadow_control_regs;
   import uart_aux_pkg::*;
   localparam int DEPTH = 4;
   // =========================================
   // Signals and model state
   logic i_clk_sys = 0, i_srst = 1, i_awvalid = 0, i_wvalid = 0, i_bready = 0, stall = 1;
   logic i_arvalid = 0, i_rready = 0, i_tx_valid = 0, i_rxq_ready = 0, i_ser_out = 1;
   logic i_sir_out_n = 1;
   logic [31:0] i_awaddr = 0, i_wdata = 0, i_araddr = 0, o_rdata;
   logic [3:0] i_wstrb = 4'hf;
   logic [7:0] i_tx_data = 0, o_txq_data, i_rx_data, o_rxq_data;
   logic [1:0] o_bresp, o_rresp;
   logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_tx_ready, o_txq_valid;
   logic i_txq_ready, i_rx_valid, o_rx_ready, o_rxq_valid, o_sout, o_sir_out_n, o_rts_n;
   logic o_loop_cts, o_loop_rxd, o_loopback, o_fifo_enable, o_core_rst;
   logic [7:0] m_mcr = 0, m_lcr = 0, m_fcr = 0;
   logic [7:0] tx_q[$], rx_q[$];
   int miscompares = 0, cmp_count = 0, cyc = 0, seen_rst = 0, lows = 0;
   integer seed = 32'hf09e;
   uart_shadow_control_regs #(.FIFO_DEPTH(DEPTH)) i_uart_shadow_control_regs (.*);
   modem_partner i_modem_partner (.i_clk_sys, .i_rts_n(o_rts_n), .i_stall(stall),
      .o_rx_valid(i_rx_valid), .o_rx_data(i_rx_data), .i_rx_ready(o_rx_ready),
      .i_txq_valid(o_txq_valid), .i_txq_data(o_txq_data), .o_txq_ready(i_txq_ready));
   always #2 i_clk_sys = ~i_clk_sys;
   // =========================================
   // Tasks
   task automatic final_report();
      if (miscompares == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge i_clk_sys);
      i_awaddr <= a;
      i_wdata <= d;
      i_awvalid <= 1;
      i_wvalid <= 1;
      i_bready <= 1;
      do begin
         @(posedge i_clk_sys);
         if (o_awready) i_awvalid <= 0;
         if (o_wready) i_wvalid <= 0;
      end while (!o_bvalid);
      i_bready <= 0;
      chk(32'(o_bresp), 32'(er));
   endtask
   task automatic ck_reg(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e,
                         input logic [1:0] er);
      @(posedge i_clk_sys);
      i_araddr <= a;
      i_arvalid <= 1;
      i_rready <= 1;
      do begin
         @(posedge i_clk_sys);
         if (o_arready) i_arvalid <= 0;
      end while (!o_rvalid);
      i_rready <= 0;
      chk(o_rdata & m, e);
      chk(32'(o_rresp), 32'(er));
   endtask
   // Model follows every accepted write; a soft reset clears the shared bits too
   task automatic wreg(input logic [31:0] a, input logic [31:0] d);
      wr(a, d, RESP_OKAY);
      if (a == ADDR_FLOW_SHADOW) m_mcr[BIT_MCR_RTS] = d[0];
      if (a == ADDR_BREAK_SHADOW) m_lcr[BIT_LCR_BREAK] = d[0];
      if (a == ADDR_MODEM_CTRL) m_mcr = d[7:0];
      if (a == ADDR_LINE_CTRL) m_lcr = d[7:0];
      if (a == ADDR_FIFO_CTRL) m_fcr = d[7:0] & 8'hc1;
      if (a == ADDR_SOFT_RESET && d[2]) tx_q.delete();
      if (a == ADDR_SOFT_RESET && d[1]) rx_q.delete();
      if (a == ADDR_SOFT_RESET && d[0]) begin
         {m_mcr, m_lcr, m_fcr} = 0;
         tx_q.delete();
         rx_q.delete();
      end
      repeat (3) @(posedge i_clk_sys);
   endtask
   task automatic push_tx(input int n);
      repeat (n) begin
         @(posedge i_clk_sys);
         i_tx_data <= 8'($random(seed));
         i_tx_valid <= 1;
         do @(posedge i_clk_sys); while (!o_tx_ready);
         i_tx_valid <= 0;
      end
   endtask
   function automatic logic rts_exp();
      int t;
      t = m_fcr[7] ? (m_fcr[6] ? DEPTH - 2 : DEPTH / 2) : (m_fcr[6] ? DEPTH / 4 : 1);
      return m_mcr[4] | !m_mcr[1] | (m_mcr[5] & m_fcr[0] & (rx_q.size() > t));
   endfunction
   // =========================================
   // Stream monitor, line stimulus and watchdog
   always @(posedge i_clk_sys) begin
      cyc++;
      i_ser_out <= 1'($random(seed));
      if (i_tx_valid && o_tx_ready) tx_q.push_back(i_tx_data);
      if (i_rx_valid && o_rx_ready) rx_q.push_back(i_rx_data);
      if (o_txq_valid && i_txq_ready) chk(32'(o_txq_data), 32'(tx_q.pop_front()));
      if (o_rxq_valid && i_rxq_ready) chk(32'(o_rxq_data), 32'(rx_q.pop_front()));
      if (o_core_rst) seen_rst++;
      if (!o_sir_out_n) lows++;
      if (cyc > 10000) begin
         miscompares++;
         final_report();
      end
   end
   // =========================================
   // Scenarios
   initial begin
      int i;
      repeat (12) @(posedge i_clk_sys);
      i_srst <= 0;
      repeat (3) @(posedge i_clk_sys);
      for (i = 0; i < 5; i++) ck_reg(ADDR_TX_FILL + 32'(4 * i), '1, 0, RESP_OKAY);
      ck_reg(32'h5000_1300, '1, 0, RESP_SLVERR);
      wr(32'h5000_1300, 32'h1, RESP_SLVERR);
      wr(ADDR_TX_FILL, 32'hffff, RESP_OKAY);
      ck_reg(ADDR_TX_FILL, '1, 0, RESP_OKAY);
      wreg(ADDR_FLOW_SHADOW, 1);
      ck_reg(ADDR_MODEM_CTRL, 32'h2, 32'h2, RESP_OKAY);
      chk(32'(o_rts_n), 32'(rts_exp()));
      wreg(ADDR_LINE_CTRL, 32'h40);
      ck_reg(ADDR_BREAK_SHADOW, '1, 1, RESP_OKAY);
      chk(32'(o_sout), 0);
      wreg(ADDR_MODEM_CTRL, 32'h12);
      chk(32'({o_rts_n, o_loop_cts, o_loop_rxd, o_loopback}), 32'hd);
      wreg(ADDR_MODEM_CTRL, 32'h42);
      lows = 0;
      repeat (800) @(posedge i_clk_sys);
      chk(32'(lows), 2);
      wreg(ADDR_BREAK_SHADOW, 0);
      ck_reg(ADDR_LINE_CTRL, 32'h40, 0, RESP_OKAY);
      wreg(ADDR_MODEM_CTRL, 32'h22);
      repeat (5) i_modem_partner.to_send.push_back(8'($random(seed)));
      for (i = 0; i < 4; i++) begin
         wreg(ADDR_FIFO_CTRL, 32'(i * 64 + 1));
         repeat (8) @(posedge i_clk_sys);
         chk(32'(o_rts_n), 32'(rts_exp()));
      end
      ck_reg(ADDR_RX_FILL, '1, 32'(rx_q.size()), RESP_OKAY);
      wreg(ADDR_FLOW_SHADOW, 0);
      wreg(ADDR_SOFT_RESET, 32'h2);
      ck_reg(ADDR_RX_FILL, '1, 0, RESP_OKAY);
      wreg(ADDR_FLOW_SHADOW, 1);
      i_rxq_ready <= 1;
      repeat (40) @(posedge i_clk_sys);
      ck_reg(ADDR_RX_FILL, '1, 32'(rx_q.size()), RESP_OKAY);
      // Fill transmit side against a stalled modem until refused
      i_tx_data <= 8'($random(seed));
      i_tx_valid <= 1;
      repeat (20) begin
         @(posedge i_clk_sys);
         if (o_tx_ready) i_tx_data <= 8'($random(seed));
      end
      chk(32'({o_tx_ready, 7'(tx_q.size())}), DEPTH + 2);
      ck_reg(ADDR_TX_FILL, '1, DEPTH + 2, RESP_OKAY);
      stall <= 0;
      do @(posedge i_clk_sys); while (!o_tx_ready);
      i_tx_valid <= 0;
      repeat (20) @(posedge i_clk_sys);
      ck_reg(ADDR_TX_FILL, '1, 0, RESP_OKAY);
      stall <= 1;
      push_tx(3);
      wreg(ADDR_SOFT_RESET, 32'h4);
      chk(32'(o_txq_valid), 0);
      ck_reg(ADDR_TX_FILL, '1, 0, RESP_OKAY);
      ck_reg(ADDR_SOFT_RESET, '1, 0, RESP_OKAY);
      push_tx(2);
      seen_rst = 0;
      wreg(ADDR_SOFT_RESET, 32'h1);
      repeat (10) @(posedge i_clk_sys);
      chk(32'(seen_rst > 0), 1);
      ck_reg(ADDR_TX_FILL, '1, 0, RESP_OKAY);
      ck_reg(ADDR_MODEM_CTRL, 32'h72, 0, RESP_OKAY);
      chk(32'(o_rts_n), 32'(rts_exp()));
      final_report();
   end
endmodule // test_uart_shadow_control_regs
`default_nettype wire
